// ==== src/charger_pin_control_select.sv ====
// Summary of operation
// - Charging is off while the charge-enable pin is low, on while high.
// - High-limit pin high selects 1500 mA input limit; else basic pin decides.
// - Basic pin low gives 100 mA limit, high gives 500 mA.
// - System-enable pull-down turns on once battery reaches weak threshold.
// - Each pin-controlled parameter starts from its sampled pin level.
// - A register write to a pin-controlled parameter overrides that pin.
// - Input supply connect or disconnect hands control back to the pins.
// - The three pin functions are fixed, not selectable at run time.
// - Limit code 1111 decodes to 2100 mA.
// - Charge-current code 01001 decodes to 500 mA.
// - System-voltage code 000 decodes to 4.3 V.
// - Charge-enable register equivalent is bit 0 of register 0x07.
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module charger_pin_control_select #(
	parameter logic [3:0] LIM_CODE_100  = 4'h0,
	parameter logic [3:0] LIM_CODE_1500 = 4'hb
) (
	// clock and reset
	input  wire logic                 REF_CLK_I,
	input  wire logic                 RESET_I,
	// register port
	input  wire chgsel_pkg::reg_req_t REG_REQ_I,
	output var  logic [7:0]           REG_RDATA_O,
	// control pins
	input  wire logic                 CHARGE_ENABLE_PIN_I,
	input  wire logic                 HIGH_LIMIT_SELECT_PIN_I,
	input  wire logic                 BASIC_LIMIT_SELECT_PIN_I,
	// analog status
	input  wire logic                 INPUT_SUPPLY_PRESENT_I,
	input  wire logic                 BATTERY_ABOVE_WEAK_I,
	// open-drain system-enable flag
	output var  logic                 SYSTEM_ENABLE_FLAG_O,
	output var  logic                 SYSTEM_ENABLE_FLAG_OE_O,
	// applied settings and interrupt
	output var  chgsel_pkg::setting_t SETTING_O,
	output var  logic                 IRQ_O
);
	import chgsel_pkg::*;

	// limit code to milliamps; codes without a known value read as zero
	function automatic logic [11:0] limit_ma_of(input logic [3:0] code);
		logic [11:0] ma;
		ma = 12'h000;
		if (code == LIM_CODE_2100) ma = LIM_MA_2100;
		else if (code == LIM_CODE_500) ma = LIM_MA_500;
		else if (code == LIM_CODE_1500) ma = LIM_MA_1500;
		else if (code == LIM_CODE_100) ma = LIM_MA_100;
		return ma;
	endfunction

	// charge-current code to milliamps
	function automatic logic [11:0] chg_ma_of(input logic [4:0] code);
		logic [11:0] ma;
		ma = 12'h000;
		if (code == CUR_CODE_500) ma = CUR_MA_500;
		else if (code == CUR_CODE_750) ma = CUR_MA_750;
		return ma;
	endfunction

	// system-voltage code to millivolts
	function automatic logic [12:0] sys_mv_of(input logic [2:0] code);
		logic [12:0] mv;
		mv = 13'h0000;
		if (code == VSYS_CODE_4V3) mv = VSYS_MV_4V3;
		return mv;
	endfunction

	// register address match for a write
	function automatic logic wr_hit(input reg_req_t req, input logic [ADDR_W-1:0] a);
		return req.wr && (req.addr == a);
	endfunction

	// state
	logic              ovr_chg;
	logic              ovr_lim;
	logic              chg_bit;
	logic              ldo_dis;
	logic [3:0]        lim_reg;
	logic [4:0]        chg_cur;
	logic [2:0]        sys_v;
	logic              supply_q;
	logic              bat_good;
	logic [NUM_EV-1:0] int_stat;
	logic [NUM_EV-1:0] int_mask;
	logic [7:0]        rdata;
	setting_t          setting;

	logic              next_ovr_chg;
	logic              next_ovr_lim;
	logic              next_chg_bit;
	logic              next_ldo_dis;
	logic [3:0]        next_lim_reg;
	logic [4:0]        next_chg_cur;
	logic [2:0]        next_sys_v;
	logic [NUM_EV-1:0] next_int_stat;
	logic [NUM_EV-1:0] next_int_mask;
	logic [7:0]        next_rdata;
	setting_t          next_setting;

	logic              supply_changed;
	logic [3:0]        pin_lim_code;
	logic              eff_chg_en;
	logic [3:0]        eff_lim_code;
	logic [NUM_EV-1:0] events;

	// pins have fixed meanings; nothing in the map re-purposes them
	assign pin_lim_code = HIGH_LIMIT_SELECT_PIN_I ? LIM_CODE_1500 :
		(BASIC_LIMIT_SELECT_PIN_I ? LIM_CODE_500 : LIM_CODE_100);
	// flag clear means the live pin level governs, which is also the start-up value
	assign eff_chg_en   = ovr_chg ? chg_bit : CHARGE_ENABLE_PIN_I;
	assign eff_lim_code = ovr_lim ? lim_reg : pin_lim_code;
	assign supply_changed = INPUT_SUPPLY_PRESENT_I != supply_q;

	// interrupt events
	always_comb begin
		events = '0;
		events[EV_CONNECT]  = INPUT_SUPPLY_PRESENT_I && !supply_q;
		events[EV_DISCONN]  = !INPUT_SUPPLY_PRESENT_I && supply_q;
		events[EV_BAT_GOOD] = BATTERY_ABOVE_WEAK_I && !bat_good;
	end

	// override flags and register-held parameters
	always_comb begin
		next_ovr_chg = ovr_chg;
		next_ovr_lim = ovr_lim;
		next_chg_bit = chg_bit;
		next_ldo_dis = ldo_dis;
		next_lim_reg = lim_reg;
		next_chg_cur = chg_cur;
		next_sys_v   = sys_v;
		// supply change drops overrides; a write in the same cycle still lands
		if (supply_changed) begin
			next_ovr_chg = 1'b0;
			next_ovr_lim = 1'b0;
		end
		if (wr_hit(REG_REQ_I, CHG_CTRL_ADDR)) begin
			next_ovr_chg = 1'b1;
			next_chg_bit = REG_REQ_I.wdata[CHG_EN_BIT];
			next_ldo_dis = REG_REQ_I.wdata[LDO_DIS_BIT];
		end
		if (wr_hit(REG_REQ_I, LIMIT_ADDR)) begin
			next_ovr_lim = 1'b1;
			next_lim_reg = REG_REQ_I.wdata[LIMIT_LSB +: 4];
		end
		if (wr_hit(REG_REQ_I, CHG_CUR_ADDR))
			next_chg_cur = REG_REQ_I.wdata[CHG_CUR_LSB +: 5];
		if (wr_hit(REG_REQ_I, SYS_V_ADDR))
			next_sys_v = REG_REQ_I.wdata[SYS_V_LSB +: 3];
	end

	// interrupt status and mask; a new event beats a same-cycle clear
	always_comb begin
		next_int_stat = int_stat;
		next_int_mask = int_mask;
		if (wr_hit(REG_REQ_I, INT_STAT_ADDR))
			next_int_stat = int_stat & ~REG_REQ_I.wdata[NUM_EV-1:0];
		next_int_stat = next_int_stat | events;
		if (wr_hit(REG_REQ_I, INT_MASK_ADDR))
			next_int_mask = REG_REQ_I.wdata[NUM_EV-1:0];
	end

	// read data, valid only in the cycle after the strobe
	always_comb begin
		next_rdata = 8'h00;
		if (REG_REQ_I.rd) begin
			unique case (REG_REQ_I.addr)
				CHG_CTRL_ADDR: begin
					next_rdata[CHG_EN_BIT]  = eff_chg_en;
					next_rdata[LDO_DIS_BIT] = ldo_dis;
				end
				LIMIT_ADDR:    next_rdata[LIMIT_LSB +: 4]   = eff_lim_code;
				CHG_CUR_ADDR:  next_rdata[CHG_CUR_LSB +: 5] = chg_cur;
				SYS_V_ADDR:    next_rdata[SYS_V_LSB +: 3]   = sys_v;
				STATUS_ADDR: begin
					next_rdata[ST_SUPPLY]   = supply_q;
					next_rdata[ST_BAT_GOOD] = bat_good;
					next_rdata[ST_OVR_CHG]  = ovr_chg;
					next_rdata[ST_OVR_LIM]  = ovr_lim;
				end
				INT_STAT_ADDR: next_rdata[NUM_EV-1:0] = int_stat;
				INT_MASK_ADDR: next_rdata[NUM_EV-1:0] = int_mask;
				default:       next_rdata = 8'h00;
			endcase
		end
	end

	// applied settings, registered so the analog side sees no glitches
	always_comb begin
		next_setting            = '0;
		next_setting.chg_en     = eff_chg_en;
		next_setting.ldo_dis    = ldo_dis;
		next_setting.limit_code = eff_lim_code;
		next_setting.limit_ma   = limit_ma_of(eff_lim_code);
		next_setting.chg_ma     = chg_ma_of(chg_cur);
		next_setting.sys_mv     = sys_mv_of(sys_v);
	end

	// all state registers
	always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			ovr_chg  <= 1'b0;
			ovr_lim  <= 1'b0;
			chg_bit  <= 1'b0;
			ldo_dis  <= 1'b0;
			lim_reg  <= LIMIT_RST;
			chg_cur  <= CHG_CUR_RST;
			sys_v    <= SYS_V_RST;
			supply_q <= 1'b0;
			bat_good <= 1'b0;
			int_stat <= '0;
			int_mask <= '0;
			rdata    <= 8'h00;
			setting  <= '0;
		end else begin
			ovr_chg  <= next_ovr_chg;
			ovr_lim  <= next_ovr_lim;
			chg_bit  <= next_chg_bit;
			ldo_dis  <= next_ldo_dis;
			lim_reg  <= next_lim_reg;
			chg_cur  <= next_chg_cur;
			sys_v    <= next_sys_v;
			supply_q <= INPUT_SUPPLY_PRESENT_I;
			bat_good <= BATTERY_ABOVE_WEAK_I;
			int_stat <= next_int_stat;
			int_mask <= next_int_mask;
			rdata    <= next_rdata;
			setting  <= next_setting;
		end
	end

	// outputs; the flag pin only ever pulls low
	assign REG_RDATA_O             = rdata;
	assign SETTING_O               = setting;
	assign SYSTEM_ENABLE_FLAG_O    = 1'b0;
	assign SYSTEM_ENABLE_FLAG_OE_O = bat_good;
	assign IRQ_O                   = |(int_stat & int_mask);

	// checks
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RESET_I);

	pin_charge_a: assert property (!ovr_chg |=> SETTING_O.chg_en == $past(CHARGE_ENABLE_PIN_I))
		else $error("charge enable does not follow its pin");
	high_limit_a: assert property (!ovr_lim && HIGH_LIMIT_SELECT_PIN_I |=> SETTING_O.limit_ma == LIM_MA_1500)
		else $error("high-limit pin did not give 1500 mA");
	basic_limit_a: assert property (!ovr_lim && !HIGH_LIMIT_SELECT_PIN_I |=>
		SETTING_O.limit_ma == ($past(BASIC_LIMIT_SELECT_PIN_I) ? LIM_MA_500 : LIM_MA_100))
		else $error("basic-limit pin gave wrong limit");
	sys_flag_a: assert property (BATTERY_ABOVE_WEAK_I |=> SYSTEM_ENABLE_FLAG_OE_O && !SYSTEM_ENABLE_FLAG_O)
		else $error("system-enable pull-down not on with good battery");
	reg_override_a: assert property (wr_hit(REG_REQ_I, CHG_CTRL_ADDR) |=>
		ovr_chg ##1 SETTING_O.chg_en == $past(REG_REQ_I.wdata[CHG_EN_BIT], 2))
		else $error("charge enable write did not override pin");
	lim_override_a: assert property (wr_hit(REG_REQ_I, LIMIT_ADDR) |=>
		ovr_lim ##1 SETTING_O.limit_code == $past(REG_REQ_I.wdata[3:0], 2))
		else $error("limit write did not override pins");
	supply_hand_a: assert property (supply_changed && !REG_REQ_I.wr |=> !ovr_chg && !ovr_lim)
		else $error("supply change kept an override");
	lim_decode_a: assert property (eff_lim_code == LIM_CODE_2100 |=> SETTING_O.limit_ma == LIM_MA_2100)
		else $error("limit code 1111 not 2100 mA");
	cur_decode_a: assert property (chg_cur == CUR_CODE_500 |=> SETTING_O.chg_ma == CUR_MA_500)
		else $error("charge code 01001 not 500 mA");
	vsys_decode_a: assert property (sys_v == VSYS_CODE_4V3 |=> SETTING_O.sys_mv == VSYS_MV_4V3)
		else $error("system code 000 not 4.3 V");
	ctrl_read_a: assert property (REG_REQ_I.rd && REG_REQ_I.addr == CHG_CTRL_ADDR |=>
		REG_RDATA_O[CHG_EN_BIT] == $past(eff_chg_en))
		else $error("register 0x07 bit 0 does not show charge enable");
	ldo_apply_a: assert property (wr_hit(REG_REQ_I, CHG_CTRL_ADDR) |=> ##1
		SETTING_O.ldo_dis == $past(REG_REQ_I.wdata[LDO_DIS_BIT], 2))
		else $error("regulator disable write did not reach the settings");

	// no write in the event cycle or the next, so a clear cannot end it early
	connect_irq_a: assert property (events[EV_CONNECT] && int_mask[EV_CONNECT] && !REG_REQ_I.wr ##1
		!REG_REQ_I.wr |-> IRQ_O[*2])
		else $error("connect event did not raise interrupt");
	stat_sticky_a: assert property (int_stat[EV_CONNECT] && !wr_hit(REG_REQ_I, INT_STAT_ADDR) |=>
		int_stat[EV_CONNECT])
		else $error("connect status bit dropped without a clear");
	event_wins_a: assert property (events[EV_DISCONN] |=> int_stat[EV_DISCONN])
		else $error("disconnect event lost to a clear");

	// read port keeps its one-cycle window
	read_idle_a: assert property (!REG_REQ_I.rd |=> REG_RDATA_O == 8'h00)
		else $error("read data outside the read window");
	lim_read_a: assert property (REG_REQ_I.rd && REG_REQ_I.addr == LIMIT_ADDR |=>
		REG_RDATA_O[LIMIT_LSB +: 4] == $past(eff_lim_code))
		else $error("limit register does not show applied code");

	// while a flag is set the pin level must not reach the applied value
	chg_hold_a: assert property (ovr_chg |=> SETTING_O.chg_en == $past(chg_bit))
		else $error("charge enable left the register value");
	lim_hold_a: assert property (ovr_lim |=> SETTING_O.limit_code == $past(lim_reg))
		else $error("limit code left the register value");
	flag_off_a: assert property (!BATTERY_ABOVE_WEAK_I |=> !SYSTEM_ENABLE_FLAG_OE_O)
		else $error("system-enable pull-down on with weak battery");

	// main scenarios
	reconnect_c: cover property (events[EV_CONNECT] && int_mask[EV_CONNECT]);
	override_c:  cover property (wr_hit(REG_REQ_I, CHG_CTRL_ADDR) ##[1:20] supply_changed);
	limit_ovr_c: cover property (wr_hit(REG_REQ_I, LIMIT_ADDR) ##1 ovr_lim);
	bat_good_c:  cover property ($rose(SYSTEM_ENABLE_FLAG_OE_O));
	irq_c:       cover property ($rose(IRQ_O) ##[1:10] $fell(IRQ_O));
endmodule
`default_nettype wire

// ==== src/chgsel_pkg.sv ====
`default_nettype none
package chgsel_pkg;
	// register bus widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// register map
	localparam logic [ADDR_W-1:0] CHG_CTRL_ADDR = 8'h07;
	localparam logic [ADDR_W-1:0] LIMIT_ADDR    = 8'h10;
	localparam logic [ADDR_W-1:0] CHG_CUR_ADDR  = 8'h11;
	localparam logic [ADDR_W-1:0] SYS_V_ADDR    = 8'h12;
	localparam logic [ADDR_W-1:0] STATUS_ADDR   = 8'h13;
	localparam logic [ADDR_W-1:0] INT_STAT_ADDR = 8'h14;
	localparam logic [ADDR_W-1:0] INT_MASK_ADDR = 8'h15;

	// field positions
	localparam int CHG_EN_BIT   = 0;
	localparam int LDO_DIS_BIT  = 3;
	localparam int LIMIT_LSB    = 0;
	localparam int CHG_CUR_LSB  = 0;
	localparam int SYS_V_LSB    = 0;
	localparam int ST_SUPPLY    = 0;
	localparam int ST_BAT_GOOD  = 1;
	localparam int ST_OVR_CHG   = 2;
	localparam int ST_OVR_LIM   = 3;
	localparam int EV_CONNECT   = 0;
	localparam int EV_DISCONN   = 1;
	localparam int EV_BAT_GOOD  = 2;
	localparam int NUM_EV       = 3;

	// field codes and their decoded values
	localparam logic [3:0]  LIM_CODE_2100 = 4'hf;
	localparam logic [3:0]  LIM_CODE_500  = 4'h6;
	localparam logic [11:0] LIM_MA_100    = 12'h064;
	localparam logic [11:0] LIM_MA_500    = 12'h1f4;
	localparam logic [11:0] LIM_MA_1500   = 12'h5dc;
	localparam logic [11:0] LIM_MA_2100   = 12'h834;
	localparam logic [4:0]  CUR_CODE_500  = 5'h09;
	localparam logic [4:0]  CUR_CODE_750  = 5'h0e;
	localparam logic [11:0] CUR_MA_500    = 12'h1f4;
	localparam logic [11:0] CUR_MA_750    = 12'h2ee;
	localparam logic [2:0]  VSYS_CODE_4V3 = 3'h0;
	localparam logic [12:0] VSYS_MV_4V3   = 13'h10cc;

	// reset values
	localparam logic [4:0]  CHG_CUR_RST  = 5'h09;
	localparam logic [2:0]  SYS_V_RST    = 3'h0;
	localparam logic [3:0]  LIMIT_RST    = 4'h6;

	// register port request
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

	// applied settings toward the analog loops
	typedef struct packed {
		logic        chg_en;
		logic        ldo_dis;
		logic [3:0]  limit_code;
		logic [11:0] limit_ma;
		logic [11:0] chg_ma;
		logic [12:0] sys_mv;
	} setting_t;
endpackage
`default_nettype wire

// ==== tb/pin_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_host_model (
	// requested drive per pin: [2] charge, [1] high limit, [0] basic limit
	input  wire logic [2:0] drive_en_i,
	input  wire logic [2:0] level_i,
	// levels seen at the device pins
	output var  logic [2:0] pin_o
);
	// a released pin sits on the device pull-down, so it reads low
	always_comb begin
		pin_o = drive_en_i & level_i;
	end
endmodule
`default_nettype wire

// ==== tb/charger_pin_control_select_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module charger_pin_control_select_tb_top;
	import chgsel_pkg::*;
	// odd codes on purpose so a hard-wired decode shows up
	localparam logic [3:0] code_lo = 4'h3;
	localparam logic [3:0] code_hi = 4'hc;
	logic        clk;
	logic        rst;
	reg_req_t    req;
	logic [7:0]  rdata;
	logic [2:0]  pen;
	logic [2:0]  plv;
	logic [2:0]  pins;
	logic        supply;
	logic        bat;
	logic        sef;
	logic        sef_oe;
	setting_t    applied;
	logic        irq;
	logic [7:0]  d;
	logic [3:0]  exp_code;
	logic [11:0] exp_ma;
	int          n_errors;
	int          n_checks;

	pin_host_model host_u (.drive_en_i(pen), .level_i(plv), .pin_o(pins));
	charger_pin_control_select #(.LIM_CODE_100(code_lo), .LIM_CODE_1500(code_hi)) dut_u (
		.REF_CLK_I(clk), .RESET_I(rst), .REG_REQ_I(req), .REG_RDATA_O(rdata),
		.CHARGE_ENABLE_PIN_I(pins[2]), .HIGH_LIMIT_SELECT_PIN_I(pins[1]),
		.BASIC_LIMIT_SELECT_PIN_I(pins[0]), .INPUT_SUPPLY_PRESENT_I(supply),
		.BATTERY_ABOVE_WEAK_I(bat), .SYSTEM_ENABLE_FLAG_O(sef),
		.SYSTEM_ENABLE_FLAG_OE_O(sef_oe), .SETTING_O(applied), .IRQ_O(irq));

	// 10 MHz reference
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic check(input logic [12:0] seen, input logic [12:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// a gap cycle follows every strobe, so no signal is driven twice per step
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge clk);
		req <= '0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		req <= '0;
		@(negedge clk);
		d = rdata;
		check(13'(d & m), 13'(e));
	endtask

	// long enough for a write to reach the applied settings
	task automatic settle;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic check_pins(input logic [2:0] p);
		exp_code = p[1] ? code_hi : (p[0] ? LIM_CODE_500 : code_lo);
		exp_ma = p[1] ? LIM_MA_1500 : (p[0] ? LIM_MA_500 : LIM_MA_100);
		check(13'(applied.chg_en), 13'(p[2]));
		check(13'(applied.limit_code), 13'(exp_code));
		check(13'(applied.limit_ma), 13'(exp_ma));
	endtask

	task automatic drive(input logic [2:0] en, input logic [2:0] lv);
		@(posedge clk);
		pen <= en;
		plv <= lv;
		settle();
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// hang guard, about twenty times the expected run
	initial begin
		#300000;
		n_errors++;
		complete_run();
	end

	initial begin
		rst = 1'b1;
		req = '0;
		pen = 3'h0;
		plv = 3'h0;
		supply = 1'b0;
		bat = 1'b0;
		n_errors = 0;
		n_checks = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		settle();
		// reset state with every pin released
		check_pins(3'h0);
		check(13'(applied.chg_ma), 13'(CUR_MA_500));
		check(13'(applied.sys_mv), 13'(VSYS_MV_4V3));
		rd_chk(CHG_CUR_ADDR, 8'h1f, 8'(CHG_CUR_RST));
		rd_chk(SYS_V_ADDR, 8'h07, 8'(SYS_V_RST));
		rd_chk(INT_MASK_ADDR, 8'hff, 8'h00);
		rd_chk(STATUS_ADDR, 8'h0f, 8'h00);
		$display("test reset done");
		// every pin combination, then all released
		for (int i = 0; i < 8; i++) begin
			drive(3'h7, 3'(i));
			check_pins(3'(i));
		end
		drive(3'h0, 3'h7);
		check_pins(3'h0);
		$display("test pins done");
		// register overrides win over the pins
		drive(3'h7, 3'h1);
		wr_reg(CHG_CTRL_ADDR, 8'h01);
		settle();
		check(13'(applied.chg_en), 13'h1);
		wr_reg(CHG_CTRL_ADDR, 8'h08);
		drive(3'h7, 3'h5);
		check(13'(applied.chg_en), 13'h0);
		check(13'(applied.ldo_dis), 13'h1);
		rd_chk(CHG_CTRL_ADDR, 8'h09, 8'h08);
		wr_reg(LIMIT_ADDR, 8'h0f);
		drive(3'h7, 3'h7);
		check(13'(applied.limit_ma), 13'(LIM_MA_2100));
		check(13'(applied.limit_code), 13'(LIM_CODE_2100));
		rd_chk(LIMIT_ADDR, 8'h0f, 8'h0f);
		rd_chk(STATUS_ADDR, 8'h0f, 8'h0c);
		$display("test override done");
		// connect hands control back and raises a masked event
		@(posedge clk);
		supply <= 1'b1;
		settle();
		check_pins(3'h7);
		rd_chk(STATUS_ADDR, 8'h0f, 8'h01);
		check(13'(irq), 13'h0);
		rd_chk(INT_STAT_ADDR, 8'h07, 8'h01);
		wr_reg(INT_MASK_ADDR, 8'h07);
		settle();
		check(13'(irq), 13'h1);
		wr_reg(INT_STAT_ADDR, 8'h01);
		settle();
		check(13'(irq), 13'h0);
		// disconnect drops a fresh override
		wr_reg(LIMIT_ADDR, 8'h0f);
		settle();
		check(13'(applied.limit_ma), 13'(LIM_MA_2100));
		@(posedge clk);
		supply <= 1'b0;
		settle();
		check_pins(3'h7);
		check(13'(irq), 13'h1);
		rd_chk(INT_STAT_ADDR, 8'h07, 8'h02);
		wr_reg(INT_STAT_ADDR, 8'h02);
		$display("test supply done");
		// battery good turns the pull-down on
		@(posedge clk);
		bat <= 1'b1;
		settle();
		check(13'(sef_oe), 13'h1);
		check(13'(sef), 13'h0);
		rd_chk(STATUS_ADDR, 8'h02, 8'h02);
		rd_chk(INT_STAT_ADDR, 8'h07, 8'h04);
		check(13'(irq), 13'h1);
		@(posedge clk);
		bat <= 1'b0;
		settle();
		check(13'(sef_oe), 13'h0);
		$display("test battery done");
		// charge current code, unmapped place, read data window
		wr_reg(CHG_CUR_ADDR, 8'h0e);
		rd_chk(CHG_CUR_ADDR, 8'h1f, 8'h0e);
		check(13'(applied.chg_ma), 13'(CUR_MA_750));
		wr_reg(8'h20, 8'hff);
		rd_chk(8'h20, 8'hff, 8'h00);
		@(negedge clk);
		check(13'(rdata), 13'h0);
		$display("test map done");
		// reconnect with events enabled drops a charge override
		wr_reg(INT_STAT_ADDR, 8'h04);
		wr_reg(CHG_CTRL_ADDR, 8'h00);
		settle();
		check(13'(irq), 13'h0);
		check(13'(applied.chg_en), 13'h0);
		@(posedge clk);
		supply <= 1'b1;
		settle();
		check_pins(3'h7);
		check(13'(irq), 13'h1);
		rd_chk(INT_STAT_ADDR, 8'h07, 8'h01);
		$display("test reconnect done");
		complete_run();
	end
endmodule
`default_nettype wire
